// *** rtl/vrt_ctrl.sv ***
// voltage reference and temperature indicator control register, APB slave.
// assumes a 32-bit APB master on clk_sys_i; analog ready and shared-user
// levels arrive asynchronously; the ADC channel select is on clk_sys_i.
//
// Contract
// (R1) control register at 0x90c, 8 bits, writable fields reset to zero, ready read-only
// (R2) bit 7 switches the fixed voltage reference on or off
// (R3) bit 6 reads one only while the reference output is ready
// (R4) bit 5 enables the temperature indicator; disabled means no bias current
// (R5) bit 4 selects temperature range: one High, zero Low
// (R6) bits 3:2 set comparator/DAC buffer gain; 00 switches buffer off
// (R7) bits 1:0 set ADC buffer gain; 00 switches buffer off
// (R8) a dedicated ADC channel connects to the temperature indicator output
// (R9) software waits at least 25 us after selecting that channel
// (R10) after enable, ready stays low through stabilization, then rises
// (R11) ready may already read high when another user keeps the reference on
// (R12) writes to the ready bit are ignored; it shows internal status
`timescale 1ns/1ps

module vrt_ctrl
  import vrt_pkg::*;
#(
  parameter int STAB_CYCLES = `VRT_STAB_CYC,
  parameter int TEMP_ACQ_CYCLES = `VRT_TEMP_ACQ_CYC,
  parameter logic [5:0] TEMP_CHAN = `VRT_TEMP_CHAN
) (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [`VRT_ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic ref_analog_ready_i,
  input wire logic ref_shared_active_i,
  input wire logic [5:0] adc_chan_i,
  output logic ref_enable_o,
  output logic temp_enable_o,
  output logic temp_range_o,
  output logic [1:0] cmp_dac_gain_o,
  output logic [1:0] adc_gain_o,
  output logic cmp_dac_buf_on_o,
  output logic adc_buf_on_o,
  output logic temp_to_adc_o,
  output logic temp_acq_ok_o,
  output logic irq_o
);

  // ***************************************
  // address decode
  // ***************************************

  // 0 = unmapped, 1 = control, 2 = status, 3 = mask
  function automatic logic [1:0] reg_index(input logic [`VRT_ADDR_W-1:0] addr);
    logic [1:0] idx;
    idx = 2'd0;
    case (addr)
      `VRT_CTRL_ADDR: idx = 2'd1;
      `VRT_STS_ADDR: idx = 2'd2;
      `VRT_MSK_ADDR: idx = 2'd3;
      default: idx = 2'd0;
    endcase
    return idx;
  endfunction

  localparam logic [1:0] REG_NONE = 2'h0;
  localparam logic [1:0] REG_CTRL = 2'h1;
  localparam logic [1:0] REG_STS = 2'h2;
  localparam logic [1:0] REG_MSK = 2'h3;

  function automatic logic buf_on(input logic ref_en, input logic [1:0] gain);
    return ref_en && (vrt_gain_type'(gain) != VRT_GAIN_OFF);
  endfunction

  // ***************************************
  // reference state walk
  // ***************************************

  // dropping the enable always returns to off, so a re-enable settles again
  function automatic vrt_ref_state_type ref_next(input vrt_ref_state_type st, input logic en,
    input logic settled);
    vrt_ref_state_type nxt;
    nxt = st;
    case (st)
      VRT_REF_OFF: begin
        if (en) begin
          nxt = VRT_REF_SETTLE; // R2
        end
      end
      VRT_REF_SETTLE: begin
        if (!en) begin
          nxt = VRT_REF_OFF;
        end else if (settled) begin
          nxt = VRT_REF_ON; // R10
        end
      end
      VRT_REF_ON: begin
        if (!en) begin
          nxt = VRT_REF_OFF;
        end
      end
      default: begin
        nxt = VRT_REF_OFF;
      end
    endcase
    return nxt;
  endfunction

  // ***************************************
  // read data
  // ***************************************

  // unused upper bits read as zero; the ready position shows live status
  function automatic logic [31:0] read_word(input logic [1:0] sel,
    input logic [`VRT_CTRL_W-1:0] ctrl, input logic ready,
    input logic [`VRT_EVT_W-1:0] sts, input logic [`VRT_EVT_W-1:0] msk);
    logic [31:0] word;
    word = 32'h0000_0000;
    case (sel)
      REG_CTRL: begin
        word[`VRT_CTRL_W-1:0] = ctrl;
        word[`VRT_READY_BIT] = ready; // R3 R12
      end
      REG_STS: begin
        word[`VRT_EVT_W-1:0] = sts;
      end
      REG_MSK: begin
        word[`VRT_EVT_W-1:0] = msk;
      end
      default: begin
        word = 32'h0000_0000;
      end
    endcase
    return word;
  endfunction

  // ***************************************
  // event detection
  // ***************************************

  // edges are taken between two registered copies, so each ready edge and
  // each rise of the acquisition level gives exactly one event
  function automatic logic [`VRT_EVT_W-1:0] find_events(input logic ready,
    input logic ready_prev, input logic acq, input logic acq_prev);
    logic [`VRT_EVT_W-1:0] ev;
    ev = '0;
    ev[`VRT_EVT_READY_RISE] = ready && !ready_prev;
    ev[`VRT_EVT_READY_FALL] = !ready && ready_prev;
    ev[`VRT_EVT_ACQ_DONE] = acq && !acq_prev;
    return ev;
  endfunction

  // ***************************************
  // synchronisers and timers
  // ***************************************

  vrt_regs_type r_q;
  vrt_regs_type r_d;
  logic ana_ready_s;
  logic shared_s;
  logic stab_done;
  logic acq_done;
  logic stab_run;
  logic acq_run;

  logic [1:0] async_lv;
  logic [1:0] sync_lv;

  assign async_lv = {ref_shared_active_i, ref_analog_ready_i};
  assign ana_ready_s = sync_lv[0];
  assign shared_s = sync_lv[1];

  // both analog levels cross the same way; one synchroniser each
  for (genvar g = 0; g < 2; g++) begin : g_sync
    vrt_sync3 u_sync (
      .clk_sys_i(clk_sys_i),
      .reset_i(reset_i),
      .async_i(async_lv[g]),
      .level_o(sync_lv[g])
    );
  end

  // ***************************************
  // ready qualification
  // ***************************************

  logic own_settled;
  logic ready_now;

  assign own_settled = (r_q.st == VRT_REF_ON);
  // another user holding the reference up makes our own settle unnecessary
  assign ready_now = ana_ready_s && (own_settled || shared_s); // R3 R10 R11

  // stabilization only runs while the enable is set and not yet on
  assign stab_run = (r_q.st == VRT_REF_SETTLE) && r_q.ctrl[`VRT_REF_EN_BIT]; // R10

  vrt_settle_timer #(
    .CYCLES(STAB_CYCLES)
  ) u_stab (
    .clk_sys_i(clk_sys_i),
    .reset_i(reset_i),
    .run_i(stab_run),
    .done_o(stab_done)
  );

  // acquisition window restarts whenever the channel moves away and back
  assign acq_run = r_q.temp_to_adc && (adc_chan_i == TEMP_CHAN); // R9

  vrt_settle_timer #(
    .CYCLES(TEMP_ACQ_CYCLES)
  ) u_acq (
    .clk_sys_i(clk_sys_i),
    .reset_i(reset_i),
    .run_i(acq_run),
    .done_o(acq_done)
  );

  // ***************************************
  // next state
  // ***************************************

  logic [1:0] idx;
  logic acc;
  logic wr;
  logic [`VRT_EVT_W-1:0] evt;
  logic [`VRT_EVT_W-1:0] clr;

  always_comb begin
    r_d = r_q;
    idx = reg_index(paddr_i);
    acc = psel_i && penable_i;
    wr = acc && r_q.pready && pwrite_i && pstrb_i[0];
    evt = '0;
    clr = '0;

    // reference state walk
    r_d.st = ref_next(r_q.st, r_q.ctrl[`VRT_REF_EN_BIT], stab_done); // R2 R10

    r_d.ready = ready_now; // R3 R10 R11

    // events: ready edges and end of temperature acquisition window
    r_d.ready_prev = r_q.ready;
    r_d.acq_prev = acq_done;
    evt = find_events(r_q.ready, r_q.ready_prev, acq_done, r_q.acq_prev);

    // ***************************************
    // APB: one wait state, write lands on the pready edge
    // ***************************************
    r_d.pready = 1'b0;
    // the error flag falls with pready so it never outlives its answer
    r_d.pslverr = 1'b0;
    if (acc && !r_q.pready) begin
      r_d.pready = 1'b1;
      r_d.pslverr = (idx == REG_NONE);
      r_d.prdata = 32'h0000_0000;
      if (!pwrite_i) begin
        r_d.prdata = read_word(idx, r_q.ctrl, r_q.ready, r_q.sts, r_q.msk); // R3
      end
    end

    // ***************************************
    // write path
    // ***************************************
    if (wr) begin
      case (idx)
        2'd1: begin
          // ready position is masked off: stored bit stays zero
          r_d.ctrl = pwdata_i[`VRT_CTRL_W-1:0] & `VRT_CTRL_WMASK; // R1 R12
        end
        2'd2: clr = pwdata_i[`VRT_EVT_W-1:0];
        2'd3: r_d.msk = pwdata_i[`VRT_EVT_W-1:0];
        default: r_d.msk = r_q.msk;
      endcase
    end

    // ***************************************
    // status and interrupt
    // ***************************************
    // set wins over a clear in the same cycle
    r_d.sts = (r_q.sts & ~clr) | evt;
    r_d.irq = |(r_q.sts & r_q.msk);

    // ***************************************
    // analog controls
    // ***************************************
    r_d.cda_buf_on = buf_on(r_q.ctrl[`VRT_REF_EN_BIT],
                            r_q.ctrl[`VRT_CDA_GAIN_LSB +: 2]); // R6
    r_d.adc_buf_on = buf_on(r_q.ctrl[`VRT_REF_EN_BIT],
                            r_q.ctrl[`VRT_ADC_GAIN_LSB +: 2]); // R7
    // sensor path to the ADC only exists while the indicator is biased
    r_d.temp_to_adc = r_q.ctrl[`VRT_TEMP_EN_BIT]; // R4 R8
    r_d.acq_ok = acq_done; // R9
  end

  // ***************************************
  // state register
  // ***************************************

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      r_q.ctrl <= `VRT_CTRL_RST; // R1
      r_q.ready <= 1'b0;
      r_q.ready_prev <= 1'b0;
      r_q.acq_prev <= 1'b0;
      r_q.sts <= `VRT_EVT_RST;
      r_q.msk <= `VRT_EVT_RST;
      r_q.st <= VRT_REF_OFF;
      r_q.pready <= 1'b0;
      r_q.pslverr <= 1'b0;
      r_q.prdata <= 32'h0000_0000;
      r_q.cda_buf_on <= 1'b0;
      r_q.adc_buf_on <= 1'b0;
      r_q.temp_to_adc <= 1'b0;
      r_q.acq_ok <= 1'b0;
      r_q.irq <= 1'b0;
    end else begin
      r_q <= r_d;
    end
  end

  // ***************************************
  // outputs
  // ***************************************

  assign prdata_o = r_q.prdata;
  assign pready_o = r_q.pready;
  assign pslverr_o = r_q.pslverr;
  assign ref_enable_o = r_q.ctrl[`VRT_REF_EN_BIT]; // R2
  assign temp_enable_o = r_q.ctrl[`VRT_TEMP_EN_BIT]; // R4
  assign temp_range_o = r_q.ctrl[`VRT_TEMP_RNG_BIT]; // R5
  assign cmp_dac_gain_o = r_q.ctrl[`VRT_CDA_GAIN_LSB +: 2]; // R6
  assign adc_gain_o = r_q.ctrl[`VRT_ADC_GAIN_LSB +: 2]; // R7
  assign cmp_dac_buf_on_o = r_q.cda_buf_on;
  assign adc_buf_on_o = r_q.adc_buf_on;
  assign temp_to_adc_o = r_q.temp_to_adc; // R8
  assign temp_acq_ok_o = r_q.acq_ok;
  assign irq_o = r_q.irq;

endmodule

// *** rtl/vrt_defs.svh ***
// register map, field positions, reset values and timing counts of the
// voltage reference and temperature indicator control block.
// assumes a 25 MHz system clock and an APB byte address of 12 bits.
`ifndef VRT_DEFS_SVH
`define VRT_DEFS_SVH

// ***************************************
// register byte addresses
// ***************************************
`define VRT_ADDR_W 12
`define VRT_CTRL_ADDR 12'h90c
`define VRT_STS_ADDR 12'h910
`define VRT_MSK_ADDR 12'h914

// ***************************************
// control register fields
// ***************************************
`define VRT_CTRL_W 8
`define VRT_REF_EN_BIT 7
`define VRT_READY_BIT 6
`define VRT_TEMP_EN_BIT 5
`define VRT_TEMP_RNG_BIT 4
`define VRT_CDA_GAIN_LSB 2
`define VRT_ADC_GAIN_LSB 0
`define VRT_CTRL_RST 8'h00
`define VRT_CTRL_WMASK 8'hbf

// ***************************************
// event bits of status and mask
// ***************************************
`define VRT_EVT_W 3
`define VRT_EVT_READY_RISE 0
`define VRT_EVT_READY_FALL 1
`define VRT_EVT_ACQ_DONE 2
`define VRT_EVT_RST 3'h0

// ***************************************
// timing
// ***************************************
`define VRT_CLK_PERIOD_NS 40
`define VRT_TEMP_ACQ_NS 25000
`define VRT_TEMP_ACQ_CYC ((`VRT_TEMP_ACQ_NS + `VRT_CLK_PERIOD_NS - 1) / `VRT_CLK_PERIOD_NS)
`define VRT_STAB_CYC 64
`define VRT_TEMP_CHAN 6'h3c

`endif

// *** rtl/vrt_pkg.sv ***
// types shared by the voltage reference control block and its helpers.
// assumes vrt_defs.svh is on the include path.
`include "vrt_defs.svh"

package vrt_pkg;

  typedef enum logic [1:0] {
    VRT_REF_OFF = 2'b00,
    VRT_REF_SETTLE = 2'b01,
    VRT_REF_ON = 2'b10
  } vrt_ref_state_type;

  typedef enum logic [1:0] {
    VRT_GAIN_OFF = 2'b00,
    VRT_GAIN_1X = 2'b01,
    VRT_GAIN_2X = 2'b10,
    VRT_GAIN_4X = 2'b11
  } vrt_gain_type;

  typedef struct packed {
    logic [2:0] ff;
    logic level;
  } vrt_sync_type;

  typedef struct packed {
    logic [15:0] cnt;
    logic done;
  } vrt_timer_type;

  typedef struct packed {
    logic [`VRT_CTRL_W-1:0] ctrl;
    logic ready;
    logic ready_prev;
    logic acq_prev;
    logic [`VRT_EVT_W-1:0] sts;
    logic [`VRT_EVT_W-1:0] msk;
    vrt_ref_state_type st;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic cda_buf_on;
    logic adc_buf_on;
    logic temp_to_adc;
    logic acq_ok;
    logic irq;
  } vrt_regs_type;

endpackage

// *** rtl/vrt_sync3.sv ***
// three-stage synchroniser for one level from outside the clock domain.
// assumes the input may change at any time; the output follows once
// the second and third stages agree.
`timescale 1ns/1ps

module vrt_sync3
  import vrt_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic async_i,
  output logic level_o
);

  vrt_sync_type s_q;
  vrt_sync_type s_d;

  always_comb begin
    s_d = s_q;
    s_d.ff = {s_q.ff[1:0], async_i};
    // only stages two and three are compared; stage one may be metastable
    if (s_q.ff[1] == s_q.ff[2]) begin
      s_d.level = s_q.ff[2];
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign level_o = s_q.level;

endmodule

// *** rtl/vrt_settle_timer.sv ***
// settle timer: done rises after run has been high for CYCLES edges and
// stays high until run falls.
// assumes CYCLES lies between 1 and 65535.
`timescale 1ns/1ps

module vrt_settle_timer
  import vrt_pkg::*;
#(
  parameter int CYCLES = 64
) (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic run_i,
  output logic done_o
);

  vrt_timer_type t_q;
  vrt_timer_type t_d;

  always_comb begin
    t_d = t_q;
    if (!run_i) begin
      t_d = '0;
    end else if (!t_q.done) begin
      if (t_q.cnt == 16'(CYCLES - 1)) begin
        t_d.done = 1'b1;
      end else begin
        t_d.cnt = t_q.cnt + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      t_q <= '0;
    end else begin
      t_q <= t_d;
    end
  end

  assign done_o = t_q.done;

endmodule

// *** verif/vrt_ctrl_asserts.sv ***
// checker for the reference control register block, bound to vrt_ctrl.
// assumes vrt_defs.svh is on the include path.
`timescale 1ns/1ps
`include "vrt_defs.svh"
module vrt_ctrl_asserts (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [`VRT_ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic ref_enable_o,
  input wire logic temp_enable_o,
  input wire logic temp_range_o,
  input wire logic [1:0] cmp_dac_gain_o,
  input wire logic [1:0] adc_gain_o,
  input wire logic cmp_dac_buf_on_o,
  input wire logic temp_to_adc_o
);
  // ***************
  // helpers
  // ***************
  logic acc;
  logic wr_c;
  logic rd_c;
  assign acc = psel_i & penable_i & pready_o;
  assign wr_c = acc & pwrite_i & pstrb_i[0] & (paddr_i == `VRT_CTRL_ADDR);
  assign rd_c = acc & !pwrite_i & (paddr_i == `VRT_CTRL_ADDR);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);
  // ***************
  // properties
  // ***************
  AST_ONE_WAIT: assert property (psel_i & penable_i & !pready_o |=> pready_o ##1 !pready_o)
    else $error("pready timing");
  AST_UNMAPPED: assert property (acc |-> pslverr_o == !(paddr_i inside
    {`VRT_CTRL_ADDR, `VRT_STS_ADDR, `VRT_MSK_ADDR})) else $error("slave error");
  AST_RD_CTRL: assert property (rd_c |-> prdata_o[31:8] == 24'h0 && {prdata_o[7],
    prdata_o[5:0]} == {ref_enable_o, temp_enable_o, temp_range_o, cmp_dac_gain_o,
    adc_gain_o}) else $error("ctrl read");
  AST_REF_EN: assert property (wr_c |=> ref_enable_o == $past(pwdata_i[7]))
    else $error("ref enable");
  AST_TEMP_EN: assert property (wr_c |=> temp_enable_o == $past(pwdata_i[5]))
    else $error("temp enable");
  AST_RANGE: assert property (wr_c |=> temp_range_o == $past(pwdata_i[4]))
    else $error("range");
  AST_CDA: assert property (wr_c |=> cmp_dac_gain_o == $past(pwdata_i[3:2]))
    else $error("cda gain");
  AST_ADC: assert property (wr_c |=> adc_gain_o == $past(pwdata_i[1:0]))
    else $error("adc gain");
  AST_CDA_BUF: assert property (cmp_dac_buf_on_o ==
    $past(ref_enable_o && cmp_dac_gain_o != 2'b00)) else $error("cda buffer");
  AST_TEMP_ADC: assert property ($rose(temp_enable_o) |=> temp_to_adc_o)
    else $error("temp channel");
  AST_ERR_WITH_READY: assert property (pslverr_o |-> pready_o)
    else $error("error without ready");
endmodule

bind vrt_ctrl vrt_ctrl_asserts vrt_ctrl_asserts_i (.clk_sys_i, .reset_i, .psel_i,
  .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .pstrb_i, .prdata_o, .pready_o, .pslverr_o,
  .ref_enable_o, .temp_enable_o, .temp_range_o, .cmp_dac_gain_o, .adc_gain_o,
  .cmp_dac_buf_on_o, .temp_to_adc_o);

// *** verif/tb_vrt_ctrl.sv ***
// self-checking bench for vrt_ctrl: apb master tasks and a ctrl model.
// assumes the design files and the checker are compiled before it.
`timescale 1ns/1ps
`include "vrt_defs.svh"
module tb_vrt_ctrl;
  logic clk_sys_i = 0;
  logic reset_i = 1;
  logic psel = 0;
  logic pen = 0;
  logic pwr = 0;
  logic ardy = 0;
  logic shr = 0;
  logic e;
  logic [11:0] pa = 0;
  logic [31:0] pwd = 0;
  logic [31:0] rd;
  logic [31:0] prd;
  logic [3:0] ps = 4'hf;
  logic [5:0] ch = 0;
  logic prdy, perr, ren, ten, trg, cbo, abo, tta, aok, irq;
  logic [1:0] cg;
  logic [1:0] ag;
  int error_cnt = 0;
  int comparisons = 0;
  int seed = 37;
  int m;
  int i;
  int ctrl_m = 0;

  // short counts keep the run brief
  vrt_ctrl #(.STAB_CYCLES(4), .TEMP_ACQ_CYCLES(8)) vrt_ctrl_i (.clk_sys_i(clk_sys_i),
    .reset_i(reset_i), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(pa),
    .pwdata_i(pwd), .pstrb_i(ps), .prdata_o(prd), .pready_o(prdy), .pslverr_o(perr),
    .ref_analog_ready_i(ardy), .ref_shared_active_i(shr), .adc_chan_i(ch),
    .ref_enable_o(ren), .temp_enable_o(ten), .temp_range_o(trg), .cmp_dac_gain_o(cg),
    .adc_gain_o(ag), .cmp_dac_buf_on_o(cbo), .adc_buf_on_o(abo), .temp_to_adc_o(tta),
    .temp_acq_ok_o(aok), .irq_o(irq));

  initial forever #20 clk_sys_i = ~clk_sys_i;

  // ***************
  // tasks
  // ***************
  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // signals change just after a rising edge and stand until pready is seen
  // high at a rising edge; the answer and the model update use that edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys_i);
    psel <= 1;
    pen <= 0;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk_sys_i);
    pen <= 1;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (prdy !== 1'b1 && n < 20);
    if (prdy !== 1'b1) begin
      error_cnt++;
      tally_and_finish();
    end
    rd = prd;
    e = perr;
    if (w && ps[0] && a == `VRT_CTRL_ADDR) ctrl_m = d & 32'hbf;
    psel <= 0;
    pen <= 0;
  endtask

  task cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask

  // ***************
  // scenarios
  // ***************
  initial begin
    repeat (10) @(posedge clk_sys_i);
    reset_i <= 0;
    for (i = 0; i < 3; i++) begin
      apb(0, 12'(12'h90c + 4 * i), 0);
      chk(rd, 0);
    end
    apb(0, 12'h918, 0);
    chk(32'({e, rd[7:0]}), 32'h100);
    $display("test reset done");
    for (i = 0; i < 8; i++) begin
      m = $random(seed) & 8'hff;
      apb(1, `VRT_CTRL_ADDR, m);
      ps <= 4'($random(seed)) & 4'he;
      apb(1, `VRT_CTRL_ADDR, ~m);
      ps <= 4'hf;
      apb(0, `VRT_CTRL_ADDR, 0);
      chk(rd, ctrl_m);
      chk(32'({ren, 1'b0, ten, trg, cg, ag}), ctrl_m);
      chk(32'({cbo, abo}), 32'({ctrl_m[7] & |ctrl_m[3:2], ctrl_m[7] & |ctrl_m[1:0]}));
    end
    $display("test fields done");
    apb(1, `VRT_CTRL_ADDR, 0);
    ardy <= 1;
    apb(1, `VRT_CTRL_ADDR, 32'h80);
    apb(0, `VRT_CTRL_ADDR, 0);
    chk(rd, 32'h80);
    apb(1, `VRT_MSK_ADDR, 1);
    cyc(10);
    chk(32'(irq), 1);
    apb(0, `VRT_CTRL_ADDR, 0);
    chk(rd, 32'hc0);
    apb(1, `VRT_STS_ADDR, 1);
    cyc(3);
    chk(32'(irq), 0);
    apb(1, `VRT_CTRL_ADDR, 0);
    cyc(4);
    apb(0, `VRT_CTRL_ADDR, 0);
    chk(rd, 0);
    apb(0, `VRT_STS_ADDR, 0);
    chk(rd, 2);
    $display("test ready done");
    shr <= 1;
    cyc(8);
    apb(0, `VRT_CTRL_ADDR, 0);
    chk(rd, 32'h40);
    shr <= 0;
    cyc(8);
    apb(1, `VRT_STS_ADDR, 7);
    apb(1, `VRT_CTRL_ADDR, 32'h20);
    ch <= 6'h3c;
    cyc(3);
    chk(32'({tta, aok}), 2);
    cyc(12);
    chk(32'({tta, aok}), 3);
    apb(0, `VRT_STS_ADDR, 0);
    chk(32'({irq, rd[2:0]}), 4);
    $display("test temp done");
    tally_and_finish();
  end
endmodule
